// ---- tb/cenc_pipe_model.sv ----
`timescale 1ns/100ps
module cenc_pipe_model
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Instruction from the bench program
  input wire cenc_pkg::cenc_instr_t i_req,
  // Instruction into the core
  output cenc_pkg::cenc_instr_t o_instr
);
  logic [1:0] stall_q;
  logic [1:0] stall_d;
  logic trap_now;
  //////////////////////////////////////////////////////////////////////////
  // Two dead cycles after a trap, as the core drops them during save and vector
  always_comb
  begin
    trap_now = i_req.valid && (i_req.trap ||
      (i_req.word[10:5] == cenc_pkg::ILG_SUBOP &&
       i_req.word[26:23] >= cenc_pkg::ILG_MIN));
    stall_d = 2'h0;
    if (stall_q != 2'h0)
      stall_d = stall_q - 2'h1;
    else if (trap_now)
      stall_d = 2'h2;
    o_instr = i_req;
    if (stall_q != 2'h0)
      o_instr.valid = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      stall_q <= 2'h0;
    else
      stall_q <= stall_d;
  end
endmodule // cenc_pipe_model

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  logic i_mclk = 1'b0;
  logic i_reset_n = 1'b0;
  cenc_pkg::cenc_instr_t req = '0;
  cenc_pkg::cenc_instr_t nop;
  cenc_pkg::cenc_instr_t instr;
  logic i_nmi_req = 1'b0;
  logic [7:0] i_irq_req = 8'h00;
  logic i_icr_wr = 1'b0;
  logic [2:0] i_icr_idx = 3'h0;
  logic [7:0] i_icr_data = 8'h00;
  logic o_redirect, o_irq_ack;
  logic [2:0] o_ack_src;
  logic [31:0] o_redirect_pc, o_psw, o_saved_return_pc, o_saved_return_status, o_ecr;
  logic [7:0] o_in_service_level_reg, o_pend;
  int err_total = 0;
  int checks_done = 0;
  int k;
  logic [31:0] rnd = 32'h7360;
  logic [31:0] ret;
  logic [4:0] v;
  cenc_pkg::cenc_instr_t x;
  // Model: level of each source, stack of levels in service
  int m_lvl [8];
  int svc [$];
  //////////////////////////////////////////////////////////////////////////
  always #50 i_mclk = ~i_mclk;

  cenc_pipe_model pipe (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_req(req), .o_instr(instr));

  cenc_core dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_instr(instr),
    .i_nmi_req(i_nmi_req), .i_irq_req(i_irq_req), .i_icr_wr(i_icr_wr),
    .i_icr_idx(i_icr_idx), .i_icr_data(i_icr_data),
    .o_redirect(o_redirect), .o_redirect_pc(o_redirect_pc),
    .o_irq_ack(o_irq_ack), .o_ack_src(o_ack_src), .o_psw(o_psw),
    .o_saved_return_pc(o_saved_return_pc), .o_saved_return_status(o_saved_return_status), .o_ecr(o_ecr), .o_in_service_level_reg(o_in_service_level_reg),
    .o_pend(o_pend));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] exp_in_service_level_reg();
    logic [7:0] r;
    r = 8'h00;
    foreach (svc[i])
      r[svc[i]] = 1'b1;
    return r;
  endfunction

  task cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task cmp_cnt(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi)
    begin
      err_total++;
      $display("Error %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task summarize();
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task issue(input cenc_pkg::cenc_instr_t t);
    @(posedge i_mclk);
    req <= t;
    @(posedge i_mclk);
    req <= nop;
  endtask

  task op(input int c);
    cenc_pkg::cenc_instr_t t;
    t = nop;
    t.ei = (c == 0);
    t.di = (c == 1);
    t.return_from_trap_instr = (c == 2);
    issue(t);
  endtask

  task icr(input logic [2:0] idx, input logic [7:0] d);
    @(posedge i_mclk);
    i_icr_wr <= 1'b1;
    i_icr_idx <= idx;
    i_icr_data <= d;
    m_lvl[idx] = int'(d[2:0]);
    @(posedge i_mclk);
    i_icr_wr <= 1'b0;
  endtask

  task pulse(input logic [7:0] p);
    @(posedge i_mclk);
    i_irq_req <= p;
    @(posedge i_mclk);
    i_irq_req <= 8'h00;
  endtask

  // Edge 0 is the edge at which the caller's last drive was made
  task wait_redir(input int mx, output int n);
    n = mx + 1;
    #1;
    for (int i = 0; i <= mx; i++)
    begin
      if (i > 0)
      begin
        @(posedge i_mclk);
        #1;
      end
      if (o_redirect === 1'b1)
      begin
        n = i;
        break;
      end
    end
  endtask

  // Negative lo means no acknowledge may come within 20 cycles
  // Latency runs from the pulse's first edge to the redirect
  task wait_ack(input int lo, input int hi, input logic [2:0] src);
    int n;
    n = 21;
    for (int i = 1; i <= 20; i++)
    begin
      @(posedge i_mclk);
      #1;
      if (o_irq_ack === 1'b1)
      begin
        n = i;
        break;
      end
    end
    if (lo < 0)
      cmp_cnt(n, 21, 21);
    else
    begin
      cmp_cnt(n + 3, lo, hi);
      cmp_val({29'h0, o_ack_src}, {29'h0, src});
      svc.push_back(m_lvl[src]);
      // Save and vector cycles sit between acknowledge and redirect
      repeat (2) @(posedge i_mclk);
      #1;
      cmp_val({31'h0, o_redirect}, 32'h1);
      cmp_val(o_redirect_pc, cenc_pkg::VEC_IRQ + {25'h0, src, 4'h0});
      cmp_val({24'h0, o_in_service_level_reg}, {24'h0, exp_in_service_level_reg()});
    end
  endtask

  // Return from a maskable routine drops its highest level
  task return_from_trap_instr_m();
    int j;
    op(2);
    j = 0;
    foreach (svc[i])
      if (svc[i] < svc[j])
        j = i;
    svc.delete(j);
    repeat (2) @(posedge i_mclk);
    #1;
    cmp_val({24'h0, o_in_service_level_reg}, {24'h0, exp_in_service_level_reg()});
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    #1000000;
    err_total++;
    $display("Error %0t watchdog expired", $time);
    summarize();
  end

  initial
  begin
    nop = '0;
    nop.valid = 1'b1;
    repeat (8) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    req <= nop;
    #1;
    cmp_val(o_psw, cenc_pkg::PSW_RST);
    cmp_val({24'h0, o_in_service_level_reg | o_pend}, 32'h0);
    for (int f = 0; f < 16; f++)
    begin
      rnd = lfsr(rnd);
      ret = lfsr(rnd);
      rnd = ret;
      x = nop;
      x.word = rnd;
      x.word[10:5] = cenc_pkg::ILG_SUBOP;
      x.word[26:23] = 4'(f);
      x.ret_pc = ret;
      issue(x);
      wait_redir(f >= 3 ? 2 : 5, k);
      cmp_cnt(k, f >= 3 ? 2 : 6, f >= 3 ? 2 : 6);
      if (f >= 3)
      begin
        cmp_val(o_redirect_pc, cenc_pkg::VEC_ILG);
        cmp_val(o_saved_return_pc, ret);
        cmp_val(o_saved_return_status, cenc_pkg::PSW_RST);
        cmp_val({16'h0, o_ecr[15:0]}, 32'h0060);
        cmp_val(o_psw, cenc_pkg::PSW_RST | 32'h60);
        op(2);
        wait_redir(2, k);
        cmp_cnt(k, 0, 0);
        cmp_val(o_redirect_pc, ret);
        @(posedge i_mclk);
        #1;
        cmp_val(o_psw, cenc_pkg::PSW_RST);
      end
    end
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      v = {i > 1, rnd[3:0]};
      x = nop;
      x.trap = 1'b1;
      x.trap_vec = v;
      x.ret_pc = rnd;
      issue(x);
      wait_redir(3, k);
      cmp_cnt(k, 2, 2);
      cmp_val(o_redirect_pc, v[4] ? 32'h50 : 32'h40);
      cmp_val({16'h0, o_ecr[15:0]}, {16'h0, cenc_pkg::CODE_TRAP + 16'(v)});
      op(2);
      wait_redir(2, k);
    end
    op(0);
    pulse(8'h80);
    wait_ack(-1, 0, 3'h0);
    icr(3'h0, 8'h03);
    pulse(8'h01);
    wait_ack(11, 11, 3'h0);
    op(0);
    icr(3'h1, 8'h03);
    icr(3'h4, 8'h01);
    pulse(8'h02);
    wait_ack(-1, 0, 3'h0);
    pulse(8'h10);
    wait_ack(13, 13, 3'h4);
    return_from_trap_instr_m();
    wait_ack(-1, 0, 3'h0);
    return_from_trap_instr_m();
    wait_ack(1, 18, 3'h1);
    return_from_trap_instr_m();
    op(1);
    icr(3'h2, 8'h00);
    icr(3'h3, 8'h00);
    pulse(8'h0c);
    op(0);
    // Mask-all only two clocks after unmask-all, on purpose
    op(1);
    wait_ack(-1, 0, 3'h0);
    cmp_val({24'h0, o_pend & 8'h0c}, 32'h0c);
    op(0);
    wait_ack(7, 18, 3'h2);
    wait_ack(-1, 0, 3'h0);
    return_from_trap_instr_m();
    wait_ack(1, 18, 3'h3);
    return_from_trap_instr_m();
    @(posedge i_mclk);
    i_nmi_req <= 1'b1;
    @(posedge i_mclk);
    i_nmi_req <= 1'b0;
    wait_redir(6, k);
    cmp_cnt(k, 1, 6);
    cmp_val(o_redirect_pc, cenc_pkg::VEC_NMI);
    cmp_val(o_psw & 32'h80, 32'h80);
    op(0);
    icr(3'h5, 8'h00);
    pulse(8'h20);
    wait_ack(-1, 0, 3'h0);
    op(2);
    wait_ack(1, 18, 3'h5);
    return_from_trap_instr_m();
    // Handler loads a fresh random value into its saved return PC
    rnd = lfsr(rnd);
    x = nop;
    x.load_system_reg_instr = 1'b1;
    x.sr_id = cenc_pkg::SR_SAVED_RETURN_PC;
    x.sr_data = rnd;
    issue(x);
    #1;
    cmp_val(o_saved_return_pc, rnd);
    summarize();
  end
endmodule // testbench

// ---- verilog/cenc_core.sv ----
`timescale 1ns/100ps
module cenc_core
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset_n,
  // Pipeline
  input wire cenc_pkg::cenc_instr_t i_instr,
  input wire logic i_nmi_req,
  // Peripheral requests and their control registers
  input wire logic [7:0] i_irq_req,
  input wire logic i_icr_wr,
  input wire logic [2:0] i_icr_idx,
  input wire logic [7:0] i_icr_data,
  // Redirect to pipeline
  output logic o_redirect,
  output logic [31:0] o_redirect_pc,
  output logic o_irq_ack,
  output logic [2:0] o_ack_src,
  // System registers
  output logic [31:0] o_psw,
  output logic [31:0] o_saved_return_pc,
  output logic [31:0] o_saved_return_status,
  output logic [31:0] o_ecr,
  output logic [7:0] o_in_service_level_reg,
  output logic [7:0] o_pend
);
  ////////////////////////////////////////////////////////////////////////////
  cenc_pkg::cenc_state_t state_q, state_d;
  cenc_pkg::cenc_evt_t evt_q, evt_d;
  logic [31:0] psw_q, psw_d, saved_return_pc_q, saved_return_pc_d, saved_return_status_q, saved_return_status_d;
  logic [31:0] fepc_q, fepc_d, fepsw_q, fepsw_d, ecr_q, ecr_d;
  logic [31:0] retpc_q, retpc_d, rpc_q, rpc_d;
  logic [7:0] in_service_level_reg_q, in_service_level_reg_d;
  logic redir_q, redir_d, ack_q, ack_d;
  logic [2:0] asrc_q, asrc_d;
  logic [7:0] pend_q, pend_d, ext1_q, ext2_q, req_in, clr;
  logic [7:0] icr_q [cenc_pkg::NSRC];
  logic [7:0] icr_d [cenc_pkg::NSRC];
  logic [7:0] elig;
  logic [3:0] det_q, det_d, cur_lvl;
  logic nosamp_q, nosamp_d, nmi_q, nmi_d;
  logic is_ilg, is_nosamp, cand_ok, take_irq, nmi_take;
  logic [2:0] best_src, best_pri;

  // Pin requests arrive two clocks later than internal ones
  assign req_in = (i_irq_req & ~cenc_pkg::EXT_SRC) |
    (ext2_q & cenc_pkg::EXT_SRC);
  assign is_ilg = i_instr.valid &&
    i_instr.word[10:5] == cenc_pkg::ILG_SUBOP &&
    i_instr.word[26:23] >= cenc_pkg::ILG_MIN;
  assign is_nosamp = i_instr.valid && (i_instr.ei || i_instr.di ||
    (i_instr.load_system_reg_instr && i_instr.sr_id == cenc_pkg::SR_PSW) || i_icr_wr);

  ////////////////////////////////////////////////////////////////////////////
  // Level currently in service; none means any level may enter
  always_comb
  begin
    cur_lvl = cenc_pkg::LVL_NONE;
    for (int i = 7; i >= 0; i--)
    begin
      if (in_service_level_reg_q[i])
      begin
        cur_lvl = 4'(i);
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < cenc_pkg::NSRC; g++)
    begin : g_elig
      // Only strictly higher levels than the one in service qualify
      assign elig[g] = pend_q[g] && !icr_q[g][cenc_pkg::ICR_MK] &&
        ({1'b0, icr_q[g][2:0]} < cur_lvl);
    end
  endgenerate

  always_comb
  begin
    best_src = 3'h0;
    best_pri = 3'h7;
    cand_ok = 1'b0;
    // Strict compare keeps the lowest source on a tie
    for (int i = 0; i < cenc_pkg::NSRC; i++)
    begin
      if (elig[i] && (!cand_ok || icr_q[i][2:0] < best_pri))
      begin
        cand_ok = 1'b1;
        best_src = 3'(i);
        best_pri = icr_q[i][2:0];
      end
    end
    cand_ok = cand_ok && !psw_q[cenc_pkg::PSW_ID] &&
      !psw_q[cenc_pkg::PSW_NP] && state_q == cenc_pkg::ST_IDLE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request pending, determination and sampling window
  always_comb
  begin
    clr = 8'h00;
    if (take_irq)
    begin
      clr[best_src] = 1'b1;
    end
    // A new request in the clearing cycle wins
    pend_d = (pend_q & ~clr) | req_in;
    nmi_d = (nmi_q && !nmi_take) || i_nmi_req;
    // Restarts whenever cand_ok is low, so mask-all too early loses nothing
    det_d = !cand_ok ? 4'h0 :
      (det_q == cenc_pkg::DET_CYC ? det_q : det_q + 4'h1);
    nosamp_d = i_instr.valid ? is_nosamp : nosamp_q;
    for (int i = 0; i < cenc_pkg::NSRC; i++)
    begin
      icr_d[i] = (i_icr_wr && i_icr_idx == 3'(i)) ? i_icr_data : icr_q[i];
    end
  end

  assign take_irq = cand_ok && det_q == cenc_pkg::DET_CYC && !nosamp_q &&
    !is_nosamp && !is_ilg && !(i_instr.valid && i_instr.trap) &&
    !nmi_q && !(i_instr.valid && i_instr.return_from_trap_instr);
  assign nmi_take = nmi_q && !psw_q[cenc_pkg::PSW_NP] && !is_ilg &&
    !(i_instr.valid && i_instr.trap) && state_q == cenc_pkg::ST_IDLE;

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pend_q <= 8'h00;
      ext1_q <= 8'h00;
      ext2_q <= 8'h00;
      det_q <= 4'h0;
      nosamp_q <= 1'b0;
      nmi_q <= 1'b0;
      for (int i = 0; i < cenc_pkg::NSRC; i++)
      begin
        icr_q[i] <= cenc_pkg::ICR_RST;
      end
    end
    else
    begin
      pend_q <= pend_d;
      ext1_q <= i_irq_req & cenc_pkg::EXT_SRC;
      ext2_q <= ext1_q;
      det_q <= det_d;
      nosamp_q <= nosamp_d;
      nmi_q <= nmi_d;
      icr_q <= icr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Entry, save, vector and return
  always_comb
  begin
    state_d = state_q;
    evt_d = evt_q;
    psw_d = psw_q;
    saved_return_pc_d = saved_return_pc_q;
    saved_return_status_d = saved_return_status_q;
    fepc_d = fepc_q;
    fepsw_d = fepsw_q;
    ecr_d = ecr_q;
    retpc_d = retpc_q;
    rpc_d = rpc_q;
    in_service_level_reg_d = in_service_level_reg_q;
    redir_d = 1'b0;
    ack_d = 1'b0;
    asrc_d = asrc_q;
    case (state_q)
      cenc_pkg::ST_IDLE:
      begin
        retpc_d = i_instr.ret_pc;
        if (is_ilg)
        begin
          evt_d = '{cenc_pkg::EV_ILG, cenc_pkg::CODE_ILG,
            cenc_pkg::VEC_ILG, 3'h0};
          state_d = cenc_pkg::ST_SAVE;
        end
        else if (i_instr.valid && i_instr.trap)
        begin
          evt_d = '{cenc_pkg::EV_TRAP,
            cenc_pkg::CODE_TRAP + {11'h000, i_instr.trap_vec},
            i_instr.trap_vec[4] ? cenc_pkg::VEC_TRAP_HI :
            cenc_pkg::VEC_TRAP_LO, 3'h0};
          state_d = cenc_pkg::ST_SAVE;
        end
        else if (nmi_take)
        begin
          evt_d = '{cenc_pkg::EV_NMI, cenc_pkg::CODE_NMI,
            cenc_pkg::VEC_NMI, 3'h0};
          state_d = cenc_pkg::ST_SAVE;
        end
        else if (take_irq)
        begin
          evt_d = '{cenc_pkg::EV_IRQ,
            cenc_pkg::CODE_IRQ + {9'h000, best_src, 4'h0},
            cenc_pkg::VEC_IRQ + {25'h0, best_src, 4'h0}, best_pri};
          ack_d = 1'b1;
          asrc_d = best_src;
          state_d = cenc_pkg::ST_SAVE;
        end
        else if (i_instr.valid && i_instr.return_from_trap_instr)
        begin
          redir_d = 1'b1;
          if (psw_q[cenc_pkg::PSW_EP])
          begin
            psw_d = saved_return_status_q;
            rpc_d = saved_return_pc_q;
          end
          else if (psw_q[cenc_pkg::PSW_NP])
          begin
            psw_d = fepsw_q;
            rpc_d = fepc_q;
          end
          else
          begin
            psw_d = saved_return_status_q;
            rpc_d = saved_return_pc_q;
            in_service_level_reg_d = in_service_level_reg_q & (in_service_level_reg_q - 8'h01);
          end
        end
        else if (i_instr.valid && i_instr.ei)
        begin
          psw_d[cenc_pkg::PSW_ID] = 1'b0;
        end
        else if (i_instr.valid && i_instr.di)
        begin
          psw_d[cenc_pkg::PSW_ID] = 1'b1;
        end
        else if (i_instr.valid && i_instr.load_system_reg_instr)
        begin
          // Lets software keep the saved pair across nesting
          case (i_instr.sr_id)
            cenc_pkg::SR_PSW: psw_d = {24'h0, i_instr.sr_data[7:0]};
            cenc_pkg::SR_SAVED_RETURN_PC: saved_return_pc_d = i_instr.sr_data;
            cenc_pkg::SR_SAVED_RETURN_STATUS: saved_return_status_d = {24'h0, i_instr.sr_data[7:0]};
            default: psw_d = psw_q;
          endcase
        end
      end
      cenc_pkg::ST_SAVE:
      begin
        state_d = cenc_pkg::ST_VECT;
        if (evt_q.kind == cenc_pkg::EV_NMI)
        begin
          fepc_d = retpc_q;
          fepsw_d = psw_q;
          ecr_d[31:16] = evt_q.code;
          psw_d[cenc_pkg::PSW_NP] = 1'b1;
          psw_d[cenc_pkg::PSW_ID] = 1'b1;
        end
        else
        begin
          saved_return_pc_d = retpc_q;
          saved_return_status_d = psw_q;
          ecr_d[15:0] = evt_q.code;
          psw_d[cenc_pkg::PSW_ID] = 1'b1;
          if (evt_q.kind == cenc_pkg::EV_IRQ)
          begin
            in_service_level_reg_d[evt_q.pri] = 1'b1;
          end
          else
          begin
            psw_d[cenc_pkg::PSW_EP] = 1'b1;
          end
        end
      end
      cenc_pkg::ST_VECT:
      begin
        redir_d = 1'b1;
        rpc_d = evt_q.vec;
        state_d = cenc_pkg::ST_IDLE;
      end
      default:
      begin
        state_d = cenc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_q <= cenc_pkg::ST_IDLE;
      evt_q <= '0;
      psw_q <= cenc_pkg::PSW_RST;
      saved_return_pc_q <= 32'h0;
      saved_return_status_q <= 32'h0;
      fepc_q <= 32'h0;
      fepsw_q <= 32'h0;
      ecr_q <= 32'h0;
      retpc_q <= 32'h0;
      rpc_q <= 32'h0;
      in_service_level_reg_q <= 8'h00;
      redir_q <= 1'b0;
      ack_q <= 1'b0;
      asrc_q <= 3'h0;
    end
    else
    begin
      state_q <= state_d;
      evt_q <= evt_d;
      psw_q <= psw_d;
      saved_return_pc_q <= saved_return_pc_d;
      saved_return_status_q <= saved_return_status_d;
      fepc_q <= fepc_d;
      fepsw_q <= fepsw_d;
      ecr_q <= ecr_d;
      retpc_q <= retpc_d;
      rpc_q <= rpc_d;
      in_service_level_reg_q <= in_service_level_reg_d;
      redir_q <= redir_d;
      ack_q <= ack_d;
      asrc_q <= asrc_d;
    end
  end

  assign o_redirect = redir_q;
  assign o_redirect_pc = rpc_q;
  assign o_irq_ack = ack_q;
  assign o_ack_src = asrc_q;
  assign o_psw = psw_q;
  assign o_saved_return_pc = saved_return_pc_q;
  assign o_saved_return_status = saved_return_status_q;
  assign o_ecr = ecr_q;
  assign o_in_service_level_reg = in_service_level_reg_q;
  assign o_pend = pend_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  property p_ilg_take;
    state_q == cenc_pkg::ST_IDLE && is_ilg |=> state_q == cenc_pkg::ST_SAVE
      && evt_q.kind == cenc_pkg::EV_ILG;
  endproperty
  a_ilg_take: assert property (p_ilg_take)
    else $error("bad opcode not taken");

  property p_save_pc;
    state_q == cenc_pkg::ST_SAVE && evt_q.kind != cenc_pkg::EV_NMI |=>
      saved_return_pc_q == $past(retpc_q) && saved_return_status_q == $past(psw_q);
  endproperty
  a_save_pc: assert property (p_save_pc)
    else $error("saved pair wrong");

  property p_ilg_code;
    state_q == cenc_pkg::ST_SAVE && evt_q.kind == cenc_pkg::EV_ILG |=>
      ecr_q[15:0] == 16'h0060 && psw_q[6] && psw_q[5];
  endproperty
  a_ilg_code: assert property (p_ilg_code)
    else $error("cause or flags wrong");

  property p_ilg_vec;
    is_ilg && state_q == cenc_pkg::ST_IDLE |-> ##3 o_redirect &&
      o_redirect_pc == 32'h0000_0060;
  endproperty
  a_ilg_vec: assert property (p_ilg_vec)
    else $error("bad opcode vector wrong");

  property p_return_from_trap_instr;
    state_q == cenc_pkg::ST_IDLE && i_instr.valid && i_instr.return_from_trap_instr &&
      psw_q[6] && !is_ilg && !i_instr.trap && !nmi_take && !take_irq |=>
      psw_q == $past(saved_return_status_q) && o_redirect && o_redirect_pc == $past(saved_return_pc_q);
  endproperty
  a_return_from_trap_instr: assert property (p_return_from_trap_instr)
    else $error("return restore wrong");

  property p_det;
    take_irq |-> $past(cand_ok, 7) && $past(cand_ok, 1);
  endproperty
  a_det: assert property (p_det)
    else $error("determination period too short");

  property p_nest;
    take_irq |-> (in_service_level_reg_q & ((8'h02 << best_pri) - 8'h01)) == 8'h00;
  endproperty
  a_nest: assert property (p_nest)
    else $error("equal or lower level preempted");

  property p_block;
    psw_q[7] || psw_q[5] || nosamp_q |-> !take_irq;
  endproperty
  a_block: assert property (p_block)
    else $error("request taken while blocked");

  property p_in_service_level_reg;
    state_q == cenc_pkg::ST_SAVE && evt_q.kind == cenc_pkg::EV_IRQ |=>
      in_service_level_reg_q[$past(evt_q.pri)] && psw_q[5] && !psw_q[6];
  endproperty
  a_in_service_level_reg: assert property (p_in_service_level_reg)
    else $error("in-service bit not set");
endmodule // cenc_core

// ---- verilog/cenc_pkg.sv ----
package cenc_pkg;
  // Request sources, the upper four arrive from pins
  localparam int NSRC = 8;
  localparam logic [7:0] EXT_SRC = 8'hf0;
  // Status word
  localparam logic [31:0] PSW_RST = 32'h0000_0020;
  localparam int PSW_ID = 5;
  localparam int PSW_EP = 6;
  localparam int PSW_NP = 7;
  // Bad opcode pattern
  localparam logic [5:0] ILG_SUBOP = 6'h3f;
  localparam logic [3:0] ILG_MIN = 4'h3;
  // Cause codes and handler addresses
  localparam logic [15:0] CODE_ILG = 16'h0060;
  localparam logic [15:0] CODE_NMI = 16'h0010;
  localparam logic [15:0] CODE_TRAP = 16'h0040;
  localparam logic [15:0] CODE_IRQ = 16'h0080;
  localparam logic [31:0] VEC_ILG = 32'h0000_0060;
  localparam logic [31:0] VEC_TRAP_LO = 32'h0000_0040;
  localparam logic [31:0] VEC_TRAP_HI = 32'h0000_0050;
  localparam logic [31:0] VEC_NMI = 32'h0000_0010;
  localparam logic [31:0] VEC_IRQ = 32'h0000_0080;
  // System register numbers
  localparam logic [4:0] SR_SAVED_RETURN_PC = 5'h00;
  localparam logic [4:0] SR_SAVED_RETURN_STATUS = 5'h01;
  localparam logic [4:0] SR_PSW = 5'h05;
  // Request control register: mask bit and priority field
  localparam logic [7:0] ICR_RST = 8'h47;
  localparam int ICR_MK = 6;
  localparam logic [3:0] LVL_NONE = 4'h8;
  // Determination period
  localparam int CLK_NS = 100;
  localparam int DET_NS = 700;
  localparam logic [3:0] DET_CYC = 4'((DET_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_SAVE = 3'b010,
    ST_VECT = 3'b100
  } cenc_state_t;

  typedef enum logic [1:0]
  {
    EV_ILG = 2'h0,
    EV_TRAP = 2'h1,
    EV_NMI = 2'h2,
    EV_IRQ = 2'h3
  } cenc_kind_t;

  typedef struct packed
  {
    cenc_kind_t kind;
    logic [15:0] code;
    logic [31:0] vec;
    logic [2:0] pri;
  } cenc_evt_t;

  typedef struct packed
  {
    logic valid;
    logic [31:0] word;
    logic [31:0] ret_pc;
    logic return_from_trap_instr;
    logic ei;
    logic di;
    logic load_system_reg_instr;
    logic [4:0] sr_id;
    logic [31:0] sr_data;
    logic trap;
    logic [4:0] trap_vec;
  } cenc_instr_t;
endpackage
